// >>> rtl/dtc_map.vh
// register offsets, field positions, reset values and mode codes of the dual timer
// assumes a byte-wide register port driven by the processor core on clk_sys
//
// Overview of operation
// - mode 0: 8-bit counter after 1-8 bit prescaler
// - mode 0 width defaults to 13 bits
// - mode 0 wrap to zero sets overflow flag
// - count only when run and (no gate or pin high)
// - 13-bit: high byte plus low five bits
// - setting run bit keeps count registers
// - mode 0 period 256*2^(w+1)*(div+1)
// - reload registers free scratch in unused modes
// - each timer own controls; gates at bits 7/3
// - mode 1 16-bit wrap reloads, sets flag
// - reload registers reset to zero
// - mode 1 period (65536-reload)*(div+1)
// - mode 2 low byte reloads from high byte
// - mode 2 period (256-high)*(div+1)
// - timer 1 in mode 3 holds count
// - split: t0 high byte uses t1 run, flag
// - t1 keeps running, no flag, under split
// - overflow flags set by hw, cleared on vector
// - edge flags set on edge, cleared on service
// - type bit: set falling edge, clear low level
// - mode codes 00,01,10,11
// - counter select: 0 clock, 1 count pin
// - pin sampled each clock, fall counts next cycle
`ifndef DTC_MAP_VH
`define DTC_MAP_VH
`define DTC_ADDR_CTRL 8'h88
`define DTC_ADDR_MODE 8'h89
`define DTC_ADDR_T0_LOW 8'h8a
`define DTC_ADDR_T1_LOW 8'h8b
`define DTC_ADDR_T0_HIGH 8'h8c
`define DTC_ADDR_T1_HIGH 8'h8d
`define DTC_ADDR_CTRL2 8'h91
`define DTC_ADDR_T0_RLD_LOW 8'h92
`define DTC_ADDR_T1_RLD_LOW 8'h93
`define DTC_ADDR_T0_RLD_HIGH 8'h94
`define DTC_ADDR_T1_RLD_HIGH 8'h95
`define DTC_ADDR_TICK_DIV 8'h96
`define DTC_RST_CTRL 8'h00
`define DTC_RST_MODE 8'h00
`define DTC_RST_RELOAD 8'h00
`define DTC_RST_CTRL2 8'h24
`define DTC_RST_TICK_DIV 4'h0
`define DTC_BIT_T1_OVF 7
`define DTC_BIT_T1_RUN 6
`define DTC_BIT_T0_OVF 5
`define DTC_BIT_T0_RUN 4
`define DTC_BIT_EXT1_EDGE 3
`define DTC_BIT_EXT1_TYPE 2
`define DTC_BIT_EXT0_EDGE 1
`define DTC_BIT_EXT0_TYPE 0
`define DTC_BIT_T1_GATE 7
`define DTC_BIT_T1_CSEL 6
`define DTC_BIT_T0_GATE 3
`define DTC_BIT_T0_CSEL 2
`define DTC_MODE_VAR 2'b00
`define DTC_MODE_R16 2'b01
`define DTC_MODE_R8 2'b10
`define DTC_MODE_SPLIT 2'b11
`endif

// >>> rtl/dtc_timer.v
// dual 16-bit timer/counter with four modes, control, mode and count registers
// assumes the core issues one-cycle strobes on clk_sys and pulses the vector acknowledges
//
// Added by the designer: the strobed register port.
`include "dtc_map.vh"
`default_nettype none
module dtc_timer (
  // clock and reset
  input wire clk_sys,
  input wire rst,
  // register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [7:0] reg_rdata,
  // pins, asynchronous to clk_sys
  input wire ext_irq0_pin,
  input wire ext_irq1_pin,
  input wire t0_count_pin,
  input wire t1_count_pin,
  // interrupt vector acknowledges from the core
  input wire t0_vector_ack,
  input wire t1_vector_ack,
  input wire ext0_vector_ack,
  input wire ext1_vector_ack,
  // status toward the interrupt controller
  output wire t0_overflow_flag,
  output wire t1_overflow_flag,
  output wire ext0_edge_flag,
  output wire ext1_edge_flag,
  output wire ext0_level_req,
  output wire ext1_level_req
);

  reg [7:0] ctrl_q, mode_q, ctrl2_q;
  reg [3:0] tick_div_q, tick_cnt_q;
  reg [7:0] t0_low_q, t0_high_q, t1_low_q, t1_high_q;
  reg [7:0] t0_rld_low_q, t0_rld_high_q, t1_rld_low_q, t1_rld_high_q;
  reg [3:0] sync1_q, sync2_q, prev_q;
  reg [7:0] ctrl_d, t0_low_d, t0_high_d, t1_low_d, t1_high_d;
  reg t0_ovf_ev, t1_ovf_ev, th0_ovf_ev;

  // two-flop synchronisers; index 0 irq0, 1 irq1, 2 count0, 3 count1
  wire [3:0] pins_raw = {t1_count_pin, t0_count_pin, ext_irq1_pin, ext_irq0_pin};
  always @(posedge clk_sys) begin
    if (rst) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      prev_q <= 4'h0;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end
  // high then low on consecutive samples
  wire [3:0] fall = prev_q & ~sync2_q;

  // shared tick divider: one tick every div+1 cycles
  always @(posedge clk_sys) begin
    if (rst)
      tick_cnt_q <= 4'h0;
    else if (tick_cnt_q >= tick_div_q)
      tick_cnt_q <= 4'h0;
    else
      tick_cnt_q <= tick_cnt_q + 4'h1;
  end
  wire tick = (tick_cnt_q >= tick_div_q);

  wire [1:0] t0_mode = mode_q[1:0];
  wire [1:0] t1_mode = mode_q[5:4];
  wire split = (t0_mode == `DTC_MODE_SPLIT);
  // count gating: run and (no gate or pin high)
  wire t0_en = ctrl_q[`DTC_BIT_T0_RUN] & (~mode_q[`DTC_BIT_T0_GATE] | sync2_q[0]);
  wire t1_en = ctrl_q[`DTC_BIT_T1_RUN] & (~mode_q[`DTC_BIT_T1_GATE] | sync2_q[1]);
  // input select: clock tick or pin fall
  wire t0_inc = t0_en & (mode_q[`DTC_BIT_T0_CSEL] ? fall[2] : tick);
  wire t1_inc = t1_en & (mode_q[`DTC_BIT_T1_CSEL] ? fall[3] : tick) &
                (t1_mode != `DTC_MODE_SPLIT);
  // split high byte counts ticks under the timer 1 run bit only
  wire th0_inc = split & ctrl_q[`DTC_BIT_T1_RUN] & tick;

  // prescale widths, 3 bits each, field value w gives w+1 prescale bits
  wire [2:0] t0_psw = ctrl2_q[2:0];
  wire [2:0] t1_psw = ctrl2_q[5:3];

  // mode 0 step: low byte prescaler of w+1 bits feeds the high byte
  function [16:0] dtc_var_step;
    input [7:0] lo;
    input [7:0] hi;
    input [2:0] w;
    reg [7:0] mask;
    reg [7:0] lo_n;
    reg wrap_lo;
    begin
      mask = 8'hff >> (3'h7 - w);
      lo_n = (lo & ~mask) | ((lo + 8'h01) & mask);
      wrap_lo = ((lo & mask) == mask);
      if (wrap_lo)
        dtc_var_step = {(hi == 8'hff), hi + 8'h01, lo_n};
      else
        dtc_var_step = {1'b0, hi, lo_n};
    end
  endfunction

  // generic step for one timer in modes 0..2
  function [16:0] dtc_step;
    input [1:0] m;
    input [7:0] lo;
    input [7:0] hi;
    input [7:0] rlo;
    input [7:0] rhi;
    input [2:0] w;
    begin
      case (m)
        `DTC_MODE_VAR: dtc_step = dtc_var_step(lo, hi, w);
        `DTC_MODE_R16: begin
          if ({hi, lo} == 16'hffff)
            dtc_step = {1'b1, rhi, rlo};
          else
            dtc_step = {1'b0, {hi, lo} + 16'h0001};
        end
        `DTC_MODE_R8: begin
          if (lo == 8'hff)
            dtc_step = {1'b1, hi, hi};
          else
            dtc_step = {1'b0, hi, lo + 8'h01};
        end
        default: dtc_step = {1'b0, hi, lo + 8'h01};
      endcase
    end
  endfunction

  reg [16:0] s0, s1;
  // next count values and overflow events
  always @* begin
    s0 = dtc_step(t0_mode, t0_low_q, t0_high_q, t0_rld_low_q, t0_rld_high_q, t0_psw);
    s1 = dtc_step(t1_mode, t1_low_q, t1_high_q, t1_rld_low_q, t1_rld_high_q, t1_psw);
    t0_low_d = t0_low_q;
    t0_high_d = t0_high_q;
    t1_low_d = t1_low_q;
    t1_high_d = t1_high_q;
    t0_ovf_ev = 1'b0;
    t1_ovf_ev = 1'b0;
    th0_ovf_ev = 1'b0;
    if (split) begin
      // split: two free 8-bit halves, no reload
      if (t0_inc) begin
        t0_low_d = t0_low_q + 8'h01;
        t0_ovf_ev = (t0_low_q == 8'hff);
      end
      if (th0_inc) begin
        t0_high_d = t0_high_q + 8'h01;
        th0_ovf_ev = (t0_high_q == 8'hff);
      end
    end else if (t0_inc) begin
      t0_low_d = s0[7:0];
      t0_high_d = s0[15:8];
      t0_ovf_ev = s0[16];
    end
    if (t1_inc) begin
      t1_low_d = s1[7:0];
      t1_high_d = s1[15:8];
      t1_ovf_ev = s1[16] & ~split;
    end
  end

  wire wr_ctrl = reg_wr & (reg_addr == `DTC_ADDR_CTRL);
  wire t1_flag_set = split ? th0_ovf_ev : t1_ovf_ev;
  // edge detect on external irq pins when falling-edge type selected
  wire ext0_set = ctrl_q[`DTC_BIT_EXT0_TYPE] & fall[0];
  wire ext1_set = ctrl_q[`DTC_BIT_EXT1_TYPE] & fall[1];

  // control register: software write, hardware clear, hardware set wins last
  always @* begin
    ctrl_d = wr_ctrl ? reg_wdata : ctrl_q;
    if (t0_vector_ack)
      ctrl_d[`DTC_BIT_T0_OVF] = 1'b0;
    if (t1_vector_ack)
      ctrl_d[`DTC_BIT_T1_OVF] = 1'b0;
    if (ext0_vector_ack)
      ctrl_d[`DTC_BIT_EXT0_EDGE] = 1'b0;
    if (ext1_vector_ack)
      ctrl_d[`DTC_BIT_EXT1_EDGE] = 1'b0;
    if (t0_ovf_ev)
      ctrl_d[`DTC_BIT_T0_OVF] = 1'b1;
    if (t1_flag_set)
      ctrl_d[`DTC_BIT_T1_OVF] = 1'b1;
    if (ext0_set)
      ctrl_d[`DTC_BIT_EXT0_EDGE] = 1'b1;
    if (ext1_set)
      ctrl_d[`DTC_BIT_EXT1_EDGE] = 1'b1;
  end

  // register file; a software count write overrides the counting step
  always @(posedge clk_sys) begin
    if (rst) begin
      ctrl_q <= `DTC_RST_CTRL;
      mode_q <= `DTC_RST_MODE;
      ctrl2_q <= `DTC_RST_CTRL2;
      tick_div_q <= `DTC_RST_TICK_DIV;
      t0_low_q <= 8'h00;
      t0_high_q <= 8'h00;
      t1_low_q <= 8'h00;
      t1_high_q <= 8'h00;
      t0_rld_low_q <= `DTC_RST_RELOAD;
      t0_rld_high_q <= `DTC_RST_RELOAD;
      t1_rld_low_q <= `DTC_RST_RELOAD;
      t1_rld_high_q <= `DTC_RST_RELOAD;
    end else begin
      ctrl_q <= ctrl_d; // run bit write leaves counts alone
      t0_low_q <= t0_low_d;
      t0_high_q <= t0_high_d;
      t1_low_q <= t1_low_d;
      t1_high_q <= t1_high_d;
      if (reg_wr) begin
        case (reg_addr)
          `DTC_ADDR_MODE: mode_q <= reg_wdata;
          `DTC_ADDR_CTRL2: ctrl2_q <= {2'b00, reg_wdata[5:0]};
          `DTC_ADDR_TICK_DIV: tick_div_q <= reg_wdata[3:0];
          `DTC_ADDR_T0_LOW: t0_low_q <= reg_wdata;
          `DTC_ADDR_T0_HIGH: t0_high_q <= reg_wdata;
          `DTC_ADDR_T1_LOW: t1_low_q <= reg_wdata;
          `DTC_ADDR_T1_HIGH: t1_high_q <= reg_wdata;
          `DTC_ADDR_T0_RLD_LOW: t0_rld_low_q <= reg_wdata;
          `DTC_ADDR_T0_RLD_HIGH: t0_rld_high_q <= reg_wdata;
          `DTC_ADDR_T1_RLD_LOW: t1_rld_low_q <= reg_wdata;
          `DTC_ADDR_T1_RLD_HIGH: t1_rld_high_q <= reg_wdata;
          default: ;
        endcase
      end
    end
  end

  // read data one cycle after the strobe, zero otherwise and for unmapped addresses
  always @(posedge clk_sys) begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_rd) begin
      case (reg_addr)
        `DTC_ADDR_CTRL: reg_rdata <= ctrl_q;
        `DTC_ADDR_MODE: reg_rdata <= mode_q;
        `DTC_ADDR_CTRL2: reg_rdata <= ctrl2_q;
        `DTC_ADDR_TICK_DIV: reg_rdata <= {4'h0, tick_div_q};
        `DTC_ADDR_T0_LOW: reg_rdata <= t0_low_q;
        `DTC_ADDR_T0_HIGH: reg_rdata <= t0_high_q;
        `DTC_ADDR_T1_LOW: reg_rdata <= t1_low_q;
        `DTC_ADDR_T1_HIGH: reg_rdata <= t1_high_q;
        `DTC_ADDR_T0_RLD_LOW: reg_rdata <= t0_rld_low_q;
        `DTC_ADDR_T0_RLD_HIGH: reg_rdata <= t0_rld_high_q;
        `DTC_ADDR_T1_RLD_LOW: reg_rdata <= t1_rld_low_q;
        `DTC_ADDR_T1_RLD_HIGH: reg_rdata <= t1_rld_high_q;
        default: reg_rdata <= 8'h00;
      endcase
    end else
      reg_rdata <= 8'h00;
  end

  // status outputs straight from the control flops
  assign t0_overflow_flag = ctrl_q[`DTC_BIT_T0_OVF];
  assign t1_overflow_flag = ctrl_q[`DTC_BIT_T1_OVF];
  assign ext0_edge_flag = ctrl_q[`DTC_BIT_EXT0_EDGE];
  assign ext1_edge_flag = ctrl_q[`DTC_BIT_EXT1_EDGE];
  // low-level type: request follows the synchronised pin, no latch
  assign ext0_level_req = ~ctrl_q[`DTC_BIT_EXT0_TYPE] & ~sync2_q[0];
  assign ext1_level_req = ~ctrl_q[`DTC_BIT_EXT1_TYPE] & ~sync2_q[1];

endmodule
`default_nettype wire

// >>> sim/dtc_pin_model.sv
// partner model driving the irq and count pins of both timers
// assumes the bench calls its tasks from one process only
`default_nettype none
module dtc_pin_model (
  // clock
  input wire logic clk_sys,
  // pins toward the timer
  output var logic ext_irq0_pin,
  output var logic ext_irq1_pin,
  output var logic t0_count_pin,
  output var logic t1_count_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins idle high so no false fall appears after reset
  initial begin
    ext_irq0_pin = 1'b1;
    ext_irq1_pin = 1'b1;
    t0_count_pin = 1'b1;
    t1_count_pin = 1'b1;
  end
  // low held two cycles, high three, so every level is sampled
  task automatic fall_t0(input int n);
    repeat (n) begin
      @(posedge clk_sys) t0_count_pin <= 1'b0;
      repeat (2) @(posedge clk_sys);
      t0_count_pin <= 1'b1;
      repeat (2) @(posedge clk_sys);
    end
  endtask
  // irq level for gating and trigger
  task automatic irq0(input logic v);
    @(posedge clk_sys) ext_irq0_pin <= v;
  endtask
endmodule
`default_nettype wire

// >>> sim/dtc_timer_assertions.sv
// checker for the dual timer register port and status flags
// assumes it is bound into dtc_timer and sees only that module's ports
`default_nettype none
module dtc_timer_assertions (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // acknowledges and flags
  input wire logic t0_vector_ack,
  input wire logic t1_vector_ack,
  input wire logic ext0_vector_ack,
  input wire logic t0_overflow_flag,
  input wire logic t1_overflow_flag,
  input wire logic ext0_edge_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // a control write can overwrite flags, so stickiness excludes it
  wire ctl_wr = reg_wr && reg_addr == 8'h88;
  sequence s_rd_ctrl;
    reg_rd && reg_addr == 8'h88;
  endsequence
  sequence s_rd_width;
    reg_rd && reg_addr == 8'h91;
  endsequence
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_ctrl_flags: assert property (s_rd_ctrl |=> reg_rdata[7] == $past(t1_overflow_flag) &&
    reg_rdata[5] == $past(t0_overflow_flag) && reg_rdata[1] == $past(ext0_edge_flag))
    else $error("control read does not show the flags");
  a_width_pad: assert property (s_rd_width |=> reg_rdata[7:6] == 2'b00)
    else $error("width register top bits not zero");
  a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h80 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_sw_set: assert property (ctl_wr && reg_wdata[5] |=> t0_overflow_flag)
    else $error("written flag did not set");
  a_t0_sticky: assert property (t0_overflow_flag && !t0_vector_ack && !ctl_wr |=>
    t0_overflow_flag) else $error("timer 0 flag dropped without acknowledge");
  a_t1_sticky: assert property (t1_overflow_flag && !t1_vector_ack && !ctl_wr |=>
    t1_overflow_flag) else $error("timer 1 flag dropped without acknowledge");
  a_ext0_sticky: assert property (ext0_edge_flag && !ext0_vector_ack && !ctl_wr |=>
    ext0_edge_flag) else $error("edge flag dropped without acknowledge");
endmodule
bind dtc_timer dtc_timer_assertions i_dtc_timer_assertions (.*);
`default_nettype wire

// >>> sim/tb_top.sv
// self-checking bench for the dual timer through its register port
// assumes the pin partner model and the bound checker
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0;
  logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, d;
  logic t0_vector_ack = 0, t1_vector_ack = 0, ext0_vector_ack = 0, ext1_vector_ack = 0;
  logic ext_irq0_pin, ext_irq1_pin, t0_count_pin, t1_count_pin;
  logic t0_overflow_flag, t1_overflow_flag, ext0_edge_flag, ext1_edge_flag;
  logic ext0_level_req, ext1_level_req;
  logic [7:0] ra[5] = '{8'h88, 8'h89, 8'h91, 8'h92, 8'h80};
  logic [7:0] rv[5] = '{8'h00, 8'h00, 8'h24, 8'h00, 8'h00};
  int err_count = 0, check_count = 0, p;
  always #5 clk_sys = ~clk_sys;
  dtc_timer i_dtc_timer (.*);
  dtc_pin_model i_dtc_pin_model (.*);
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // one-cycle strobes, released at the next edge
  task automatic wr(input logic [7:0] a, v);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // bounded wait on flag s (0 t0, 1 t1, 2 edge), n counts edges
  task automatic wait_flag(input int s, output int n);
    n = 0;
    while (!(3'({ext0_edge_flag, t1_overflow_flag, t0_overflow_flag}) >> s & 1)) begin
      @(posedge clk_sys);
      #1 n++;
      if (n > 3000) begin
        err_count++;
        end_sim();
      end
    end
  endtask
  // period between two sets; a stale flag from an earlier mode is acknowledged first
  task automatic per(input int s);
    @(posedge clk_sys);
    {ext0_vector_ack, t1_vector_ack, t0_vector_ack} <= 3'(1 << s);
    @(posedge clk_sys);
    {ext0_vector_ack, t1_vector_ack, t0_vector_ack} <= 3'h0;
    #1 wait_flag(s, p);
    @(posedge clk_sys);
    {ext0_vector_ack, t1_vector_ack, t0_vector_ack} <= 3'(1 << s);
    @(posedge clk_sys);
    {ext0_vector_ack, t1_vector_ack, t0_vector_ack} <= 3'h0;
    #1 wait_flag(s, p);
    p = p + 2;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    foreach (ra[i]) begin
      rd(ra[i]);
      chk("reset value", d, rv[i]);
    end
    // mode 1: reload fff0, divider 1 gives 16 ticks of 2 cycles
    wr(8'h96, 8'h01);
    wr(8'h89, 8'h01);
    wr(8'h94, 8'hff);
    wr(8'h92, 8'hf0);
    wr(8'h8c, 8'hff);
    wr(8'h8a, 8'hfe);
    wr(8'h88, 8'h10);
    per(0);
    chk("mode1 period", p, 32);
    // mode 2: high byte f8 reloads the low byte, 8 ticks of 2
    wr(8'h89, 8'h02);
    wr(8'h8c, 8'hf8);
    wr(8'h8a, 8'hf8);
    per(0);
    chk("mode2 period", p, 16);
    wr(8'h88, 8'h00);
    rd(8'h8c);
    chk("mode2 high byte", d, 8'hf8);
    // mode 0 with a one-bit prescaler, divider 0
    wr(8'h96, 8'h00);
    wr(8'h91, 8'h20);
    wr(8'h89, 8'h00);
    wr(8'h92, 8'h5a);
    wr(8'h88, 8'h10);
    per(0);
    chk("mode0 period", p, 512);
    rd(8'h92);
    chk("scratch reload", d, 8'h5a);
    // gate: pin low holds, pin high counts
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h09);
    wr(8'h8a, 8'h00);
    i_dtc_pin_model.irq0(1'b0);
    wr(8'h88, 8'h10);
    repeat (20) @(posedge clk_sys);
    rd(8'h8a);
    chk("gated hold", d, 8'h00);
    i_dtc_pin_model.irq0(1'b1);
    repeat (20) @(posedge clk_sys);
    rd(8'h8a);
    chk("gate open", 16'(d != 8'h00), 16'h0001);
    // counter: run keeps the written 5, three falls add 3
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h05);
    wr(8'h8a, 8'h05);
    wr(8'h88, 8'h10);
    i_dtc_pin_model.fall_t0(3);
    repeat (4) @(posedge clk_sys);
    rd(8'h8a);
    chk("pin count", d, 8'h08);
    // split: t0 high byte runs on t1 run bit, t1 in mode 3 holds
    wr(8'h88, 8'h00);
    wr(8'h89, 8'h33);
    wr(8'h8c, 8'hfc);
    wr(8'h8b, 8'h10);
    wr(8'h88, 8'h40);
    wait_flag(1, p);
    chk("split t0 flag", t0_overflow_flag, 1'b0);
    rd(8'h8b);
    chk("t1 held", d, 8'h10);
    // the next high byte wrap is 256 ticks away, so the clear must show at once
    @(posedge clk_sys);
    t1_vector_ack <= 1'b1;
    @(posedge clk_sys);
    t1_vector_ack <= 1'b0;
    #1 chk("t1 ack", t1_overflow_flag, 1'b0);
    // edge-triggered irq sets the flag, acknowledge clears it
    wr(8'h88, 8'h01);
    i_dtc_pin_model.irq0(1'b0);
    wait_flag(2, p);
    @(posedge clk_sys);
    ext0_vector_ack <= 1'b1;
    @(posedge clk_sys);
    ext0_vector_ack <= 1'b0;
    #1 chk("edge ack", ext0_edge_flag, 1'b0);
    wr(8'h88, 8'h00);
    repeat (3) @(posedge clk_sys);
    chk("level request", ext0_level_req, 1'b1);
    chk("idle level request", ext1_level_req, 1'b0);
    chk("idle edge flag", ext1_edge_flag, 1'b0);
    wr(8'h88, 8'h20);
    #1 chk("sw flag set", t0_overflow_flag, 1'b1);
    end_sim();
  end
endmodule
`default_nettype wire
